//--- common/alr_pkg.sv
// Purpose: Constants and types for the add-literal and add-register slice
// Assumes: One core clock, four clock edges form one instruction cycle
// Notes:
package alr_pkg;

    localparam logic [7:0] ADD_IMM_OPCODE = 8'h0F;
    localparam logic [5:0] ADD_REG_OPCODE = 6'h09;
    localparam int DEST_BIT_POS = 9;
    localparam int ACCESS_BIT_POS = 8;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam int PHASES_PER_CYCLE = 4;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } alr_phase_t;

    typedef struct packed {
        logic neg;
        logic signed_wrap_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
    } alr_flags_t;

    localparam alr_flags_t FLAGS_RESET = '0;

    typedef struct packed {
        logic [11:0] addr;
        logic rd;
        logic we;
        logic [7:0] wdata;
    } alr_mem_req_t;

    typedef struct packed {
        alr_phase_t phase;
        logic busy;
        logic is_reg;
        logic dest_mem;
        logic [7:0] operand;
        logic [11:0] addr;
        logic [7:0] acc;
        alr_flags_t flags;
        logic mem_rd;
        logic mem_we;
        logic [7:0] sum;
    } alr_state_t;

endpackage

//--- hdl/alr_adder.sv
// Purpose: 8-bit adder with status flag generation
// Assumes: Purely combinational, no carry in
// Notes: Flags computed from the full 9-bit and 5-bit partial sums
`timescale 1ns/1ps
module alr_adder
    import alr_pkg::*;
(
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    output logic [7:0] sum,
    output alr_flags_t flags
);
    logic [8:0] full;
    logic [4:0] low;

    always_comb begin
        full = {1'b0, a} + {1'b0, b};
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        sum = full[7:0];
        flags.carry = full[8];
        flags.half_carry_flag = low[4];
        flags.neg = full[7];
        flags.zero = (full[7:0] == 8'h00);
        // Same-sign inputs giving an opposite-sign result
        flags.signed_wrap_flag = (a[7] == b[7]) && (full[7] != a[7]);
    end
endmodule

//--- hdl/alr_core.sv
// Purpose: Execution slice for add-immediate and add-register instructions
// Assumes: Decode stage and data memory on SYS_CLK; memory read is
//          combinational within the operand-read phase
// Notes: Other opcodes are taken and retired as no-operations
`timescale 1ns/1ps
module alr_core
    import alr_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic [15:0] INSTR_WORD,
    input wire logic INSTR_VALID,
    output logic INSTR_READY,
    input wire logic EXT_ISA_EN,
    input wire logic [3:0] BANK_SELECT_POINTER,
    input wire logic [11:0] INDEX_BASE,
    input wire logic [7:0] MEM_RDATA,
    output alr_mem_req_t MEM_REQ,
    output logic [7:0] ACC_OUT,
    output alr_flags_t STATUS_FLAGS
);
    alr_state_t st_q;
    alr_state_t st_d;
    logic take;
    logic is_imm;
    logic is_reg;
    logic [7:0] lit;
    logic [11:0] res_addr;
    logic [7:0] alu_sum;
    alr_flags_t alu_flags;

    assign INSTR_READY = (st_q.phase == PH_Q1);
    assign take = INSTR_VALID && INSTR_READY;
    assign lit = INSTR_WORD[7:0];
    assign is_imm = (INSTR_WORD[15:8] == ADD_IMM_OPCODE);
    assign is_reg = (INSTR_WORD[15:10] == ADD_REG_OPCODE);

    // Address resolution covers all 256 offsets in banked mode and, with EXT_ISA_EN low, access mode; indexed mode only 0x00-0x5F
    always_comb begin
        if (INSTR_WORD[ACCESS_BIT_POS]) begin
            res_addr = {BANK_SELECT_POINTER, lit};
        end else if (EXT_ISA_EN && lit <= INDEXED_LIMIT) begin
            res_addr = 12'(INDEX_BASE + {4'h0, lit});
        end else if (lit < ACCESS_SPLIT) begin
            res_addr = {ACCESS_LOW_BANK, lit};
        end else begin
            res_addr = {ACCESS_HIGH_BANK, lit};
        end
    end

    alr_adder u_adder (
        .a(st_q.acc),
        .b(st_q.operand),
        .sum(alu_sum),
        .flags(alu_flags)
    );

    always_comb begin
        st_d = st_q;
        st_d.mem_we = 1'b0;
        case (st_q.phase)
            PH_Q1: begin
                st_d.phase = PH_Q2;
                st_d.busy = 1'b0;
                st_d.mem_rd = 1'b0;
                if (take && is_imm) begin
                    st_d.busy = 1'b1;
                    st_d.is_reg = 1'b0;
                    st_d.dest_mem = 1'b0;
                    st_d.operand = lit;
                end else if (take && is_reg) begin
                    st_d.busy = 1'b1;
                    st_d.is_reg = 1'b1;
                    st_d.dest_mem = INSTR_WORD[DEST_BIT_POS];
                    st_d.addr = res_addr;
                    st_d.mem_rd = 1'b1;
                end
            end
            PH_Q2: begin
                st_d.phase = PH_Q3;
                st_d.mem_rd = 1'b0;
                if (st_q.busy && st_q.is_reg) begin
                    st_d.operand = MEM_RDATA;
                end
            end
            PH_Q3: begin
                st_d.phase = PH_Q4;
                if (st_q.busy) begin
                    st_d.sum = alu_sum;
                    st_d.flags = alu_flags;
                    // Write lands in Q4 so the read in Q2 never sees it
                    if (st_q.dest_mem) begin
                        st_d.mem_we = 1'b1;
                    end else begin
                        st_d.acc = alu_sum;
                    end
                end
            end
            PH_Q4: begin
                st_d.phase = PH_Q1;
            end
            default: begin
                st_d.phase = PH_Q1;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q <= '{phase: PH_Q1, acc: ACC_RESET, flags: FLAGS_RESET,
                      default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign MEM_REQ.addr = st_q.addr;
    assign MEM_REQ.rd = st_q.mem_rd;
    assign MEM_REQ.we = st_q.mem_we;
    assign MEM_REQ.wdata = st_q.sum;
    assign ACC_OUT = st_q.acc;
    assign STATUS_FLAGS = st_q.flags;

    // Checks, all on SYS_CLK, disabled while RESETN is low
    logic [7:0] chk_a;
    assign chk_a = 8'(st_q.sum - st_q.operand);

    sequence s_quarters;
        st_q.phase == PH_Q2 ##1 st_q.phase == PH_Q3 ##1 st_q.phase == PH_Q4;
    endsequence

    sequence s_take_reg(logic d);
        take && is_reg && INSTR_WORD[DEST_BIT_POS] == d;
    endsequence

    property p_imm_sum;
        @(posedge SYS_CLK) disable iff (!RESETN)
        take && is_imm |-> ##3
            (ACC_OUT == 8'($past(ACC_OUT, 3) + $past(lit, 3)));
    endproperty
    a_imm_sum: assert property (p_imm_sum)
        else $error("Accumulator not updated by add-immediate");

    property p_other_ignored;
        @(posedge SYS_CLK) disable iff (!RESETN)
        take && !is_imm && !is_reg |->
            ##1 !st_q.busy ##2 (!MEM_REQ.we && $stable(ACC_OUT));
    endproperty
    a_other_ignored: assert property (p_other_ignored)
        else $error("Non-add instruction had an effect");

    property p_dest_acc;
        @(posedge SYS_CLK) disable iff (!RESETN)
        s_take_reg(1'b0) |-> ##3 (!MEM_REQ.we &&
            ACC_OUT == 8'($past(ACC_OUT, 3) + $past(MEM_RDATA, 2)));
    endproperty
    a_dest_acc: assert property (p_dest_acc)
        else $error("Register add to accumulator wrong");

    property p_dest_mem;
        @(posedge SYS_CLK) disable iff (!RESETN)
        s_take_reg(1'b1) |-> ##3 (MEM_REQ.we && $stable(ACC_OUT) &&
            MEM_REQ.wdata == 8'($past(ACC_OUT, 3) + $past(MEM_RDATA, 2)));
    endproperty
    a_dest_mem: assert property (p_dest_mem)
        else $error("Register add write-back wrong");

    property p_access_bank;
        @(posedge SYS_CLK) disable iff (!RESETN)
        take && is_reg && !INSTR_WORD[ACCESS_BIT_POS] && !EXT_ISA_EN |->
            ##1 (MEM_REQ.rd && MEM_REQ.addr[11:8] == ($past(lit) <
            ACCESS_SPLIT ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK));
    endproperty
    a_access_bank: assert property (p_access_bank)
        else $error("Access bank address wrong");

    property p_banked;
        @(posedge SYS_CLK) disable iff (!RESETN)
        take && is_reg && INSTR_WORD[ACCESS_BIT_POS] |-> ##1 (MEM_REQ.rd
            && MEM_REQ.addr == {$past(BANK_SELECT_POINTER), $past(lit)});
    endproperty
    a_banked: assert property (p_banked)
        else $error("Banked address wrong");

    property p_indexed;
        @(posedge SYS_CLK) disable iff (!RESETN)
        take && is_reg && !INSTR_WORD[ACCESS_BIT_POS] && EXT_ISA_EN &&
            lit <= INDEXED_LIMIT |-> ##1
            (MEM_REQ.addr == 12'($past(INDEX_BASE) + {4'h0, $past(lit)}));
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("Indexed address wrong");

    property p_flags;
        @(posedge SYS_CLK) disable iff (!RESETN)
        st_q.phase == PH_Q4 && st_q.busy |->
            STATUS_FLAGS.zero == (st_q.sum == 8'h00) &&
            STATUS_FLAGS.neg == st_q.sum[7] &&
            STATUS_FLAGS.carry == (st_q.sum < st_q.operand) &&
            STATUS_FLAGS.half_carry_flag ==
                (st_q.sum[3:0] < st_q.operand[3:0]);
    endproperty
    a_flags: assert property (p_flags)
        else $error("Status flags disagree with sum");

    property p_wrap;
        @(posedge SYS_CLK) disable iff (!RESETN)
        st_q.phase == PH_Q4 && st_q.busy |-> STATUS_FLAGS.signed_wrap_flag
            == (chk_a[7] == st_q.operand[7] && st_q.sum[7] != chk_a[7]);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("Overflow flag wrong");

    property p_phases;
        @(posedge SYS_CLK) disable iff (!RESETN)
        take |-> ##1 s_quarters ##1 INSTR_READY;
    endproperty
    a_phases: assert property (p_phases)
        else $error("Instruction cycle not four phases");
endmodule

//--- verif/alr_mem_model.sv
// Purpose: Data memory seen by the add slice
// Assumes: Read is combinational while rd is high
// Notes: Writes land on the clock edge that ends the we cycle
`timescale 1ns/1ps
module alr_mem_model
    import alr_pkg::*;
(
    input wire logic clk,
    input wire alr_mem_req_t req,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:4095];
    logic [7:0] last_q = 8'h00;

    always @(posedge clk) begin
        if (req.we) begin
            mem[req.addr] <= req.wdata;
        end
        if (req.rd) begin
            last_q <= mem[req.addr];
        end
    end

    // Idle bus shows the inverse, so a late sample never looks right
    assign rdata = req.rd ? mem[req.addr] : ~last_q;
endmodule

//--- verif/tb.sv
// Purpose: Self-checking bench for the add slice
// Assumes: One take every four cycles, memory model beside
// Notes: Inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module tb
    import alr_pkg::*;
();
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic instr_valid = 1'b0;
    logic ext_isa_en = 1'b0;
    logic [3:0] bsp = 4'h0;
    logic [11:0] index_base = 12'h123;
    logic [7:0] mem_rdata;
    logic instr_ready;
    alr_mem_req_t mem_req;
    logic [7:0] acc_out;
    alr_flags_t status_flags;
    logic [7:0] acc_m = 8'h00;
    logic [4:0] flags_m = 5'h00;
    int mismatches = 0;
    int total_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    alr_core u_alr_core (
        .SYS_CLK(sys_clk),
        .RESETN(resetn),
        .INSTR_WORD(instr_word),
        .INSTR_VALID(instr_valid),
        .INSTR_READY(instr_ready),
        .EXT_ISA_EN(ext_isa_en),
        .BANK_SELECT_POINTER(bsp),
        .INDEX_BASE(index_base),
        .MEM_RDATA(mem_rdata),
        .MEM_REQ(mem_req),
        .ACC_OUT(acc_out),
        .STATUS_FLAGS(status_flags)
    );

    alr_mem_model u_alr_mem_model (
        .clk(sys_clk),
        .req(mem_req),
        .rdata(mem_rdata)
    );

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Returns flags then sum, in the order of the flag struct
    function automatic logic [12:0] model(input logic [7:0] a,
        input logic [7:0] b);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        return {s[7], (a[7] == b[7]) && (s[7] != a[7]),
            s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction

    // Takes in Q1, checks the read cycle, returns in Q4
    task automatic run(input logic [15:0] w, input logic rd,
        input logic [11:0] ad);
        while (instr_ready !== 1'b1) begin
            @(posedge sys_clk);
            #1;
        end
        instr_word = w;
        instr_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        instr_valid = 1'b0;
        chk(instr_ready, 1'b0);
        chk(mem_req.rd, rd);
        if (rd) chk(mem_req.addr, ad);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_imm();
        logic [7:0] lits [6] = '{8'h10, 8'h15, 8'hDB, 8'h7F, 8'h01, 8'h80};
        logic [12:0] e;
        foreach (lits[i]) begin
            e = model(acc_m, lits[i]);
            run({ADD_IMM_OPCODE, lits[i]}, 1'b0, 12'h000);
            chk({status_flags, acc_out}, e);
            chk(mem_req.we, 1'b0);
            acc_m = e[7:0];
            flags_m = e[12:8];
        end
    endtask

    // Near misses of both opcodes must leave everything alone
    task automatic t_other();
        logic [12:0] e;
        e = {flags_m, acc_m};
        run(16'h0E55, 1'b0, 12'h000);
        chk({status_flags, acc_out}, e);
        run(16'h2155, 1'b0, 12'h000);
        chk({status_flags, acc_out}, e);
        chk(mem_req.we, 1'b0);
    endtask

    task automatic t_reg(input logic d, input logic a, input logic [7:0] f,
        input logic [3:0] p, input logic x, input logic [11:0] ad,
        input logic [7:0] m);
        logic [12:0] e;
        bsp = p;
        ext_isa_en = x;
        u_alr_mem_model.mem[ad] = m;
        e = model(acc_m, m);
        run({ADD_REG_OPCODE, d, a, f}, 1'b1, ad);
        chk(status_flags, e[12:8]);
        chk(mem_req.we, d);
        chk(acc_out, d ? acc_m : e[7:0]);
        if (d) chk(mem_req.wdata, e[7:0]);
        @(posedge sys_clk);
        #1;
        chk(u_alr_mem_model.mem[ad], d ? e[7:0] : m);
        chk(mem_req.we, 1'b0);
        if (!d) acc_m = e[7:0];
        flags_m = e[12:8];
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        #1;
        chk(instr_ready, 1'b1);
        chk({status_flags, acc_out}, 13'h0000);
        chk(mem_req, '0);
        resetn = 1'b1;
        t_imm();
        t_other();
        t_reg(1'b0, 1'b0, 8'h20, 4'h3, 1'b0, 12'h020, 8'h7F);
        t_reg(1'b1, 1'b0, 8'hA0, 4'h3, 1'b0, 12'hFA0, 8'h81);
        t_reg(1'b1, 1'b1, 8'hFF, 4'h5, 1'b1, 12'h5FF, 8'hFF);
        t_reg(1'b0, 1'b1, 8'h00, 4'hF, 1'b1, 12'hF00, 8'h00);
        t_reg(1'b1, 1'b0, 8'h5F, 4'h0, 1'b1, 12'h182, 8'h0E);
        t_reg(1'b0, 1'b0, 8'h60, 4'h0, 1'b1, 12'hF60, 8'h44);
        final_report();
    end

    // About 60 cycles of work; about twelve times that cuts a hang short
    initial begin
        #3500;
        mismatches++;
        final_report();
    end
endmodule
